// File: logic/pcs_pkg.sv
package pcs_pkg;
  // ==================================================================
  // timing
  localparam int unsigned CLOCK_MHZ = 125;
  localparam int unsigned GATE_TIME_NS = 45;
  // gate window rounds up to whole cycles (45 ns -> 6 cycles)
  localparam int unsigned GATE_CYCLES =
    (GATE_TIME_NS * CLOCK_MHZ + 999) / 1000;
  localparam int unsigned PCI_SLOW_MHZ = 33;
  localparam int unsigned PCI_FAST_MHZ = 66;
  // ==================================================================
  // source choice encoding
  localparam logic SEL_SOURCE_B = 1'b0;
  localparam logic SEL_SOURCE_C = 1'b1;
  localparam logic SEL_RESET = SEL_SOURCE_B;
  localparam logic [1:0] SAMPLE_RESET = 2'h0;
  localparam int unsigned SYNC_STAGES = 2;
  typedef enum logic [1:0] {
    PCS_WAIT_POWER,
    PCS_GATE,
    PCS_ARMED,
    PCS_LOCKED
  } pcs_state_e;
endpackage

// File: logic/pcs_sync.sv
`timescale 1ns/1ps
// ==================================================================
// two-flop level synchroniser, one per bit
module pcs_sync #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic enable,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta;
  initial begin
    if (WIDTH < 1) begin
      $error("pcs_sync: WIDTH must be at least 1");
    end
  end
  // meta is read only by sync_out
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      meta <= '0;
      sync_out <= '0;
    end else if (enable) begin
      meta <= async_in;
      sync_out <= meta;
    end
  end
endmodule

// File: logic/pcs_clock_select.sv
`timescale 1ns/1ps
// Summary of operation
// - at power-up sample both bridge clocks to choose source B or C
// - choice is made once at power-up and never changed later
// - sample only after power-good rises, qualified by bridge reset
// - hold internal reset inactive for 45 ns after power-good rises
// - a correct selection gives 33 MHz PCI clocks, not 66 MHz
// - processor test port is held in reset while power-good is low, released when it rises
module pcs_clock_select (
  input wire logic clock,
  input wire logic rst,
  input wire logic clock_enable,
  input wire logic supply_power_good,
  input wire logic bridge_pci_reset_n,
  input wire logic bridge1_pci_clock_out,
  input wire logic bridge2_pci_clock_out,
  output logic clock_detect_reset_n,
  output logic source_select,
  output logic select_valid,
  output logic [6:0] pci_clock_mhz,
  output logic board_power_good,
  output logic test_port_reset
);
  import pcs_pkg::*;

  // ================================================================
  // input synchronisers
  logic [3:0] pins_sync;
  pcs_sync #(
    .WIDTH(4)
  ) u_sync (
    .clock(clock),
    .rst(rst),
    .enable(clock_enable),
    .async_in({supply_power_good, bridge_pci_reset_n,
               bridge1_pci_clock_out, bridge2_pci_clock_out}),
    .sync_out(pins_sync)
  );
  logic pg_s, prst_n_s, clk1_s, clk2_s;
  assign pg_s = pins_sync[3];
  assign prst_n_s = pins_sync[2];
  assign clk1_s = pins_sync[1];
  assign clk2_s = pins_sync[0];

  // ================================================================
  // state
  typedef struct packed {
    pcs_state_e state;
    logic [3:0] gate_count;
    logic pg_prev;
    logic irst_n;
    logic sel;
    logic valid;
    logic [6:0] mhz;
    logic pwr_good;
    logic tap_reset;
  } pcs_regs_s;

  pcs_regs_s r, next_r;

  initial begin
    if (GATE_CYCLES < 1 || GATE_CYCLES > 15) begin
      $error("pcs_clock_select: gate count does not fit counter");
    end
  end

  // a bridge clock that is still high here marks the faster source;
  // the slow source is taken unless only source C toggled high
  function automatic logic pcs_pick(input logic c1, input logic c2);
    pcs_pick = (c1 & ~c2) ? SEL_SOURCE_C : SEL_SOURCE_B;
  endfunction

  // rise of synced power-good; the level before is kept in state
  function automatic logic pcs_pg_rise(input logic level, input logic prev);
    pcs_pg_rise = level & ~prev;
  endfunction

  always_comb begin
    next_r = r;
    next_r.pg_prev = pg_s;
    next_r.pwr_good = pg_s;
    next_r.tap_reset = ~pg_s;
    // internal reset follows the bridge reset except while waiting for power, inside the gate, and when power-good drops while armed
    next_r.irst_n = prst_n_s;
    case (r.state)
      PCS_WAIT_POWER: begin
        next_r.irst_n = 1'b1;
        if (pcs_pg_rise(pg_s, r.pg_prev)) begin
          next_r.state = PCS_GATE;
          next_r.gate_count = 4'(GATE_CYCLES);
        end
      end
      PCS_GATE: begin
        // glitchy bridge clocks during supply ramp are kept out
        next_r.irst_n = 1'b1;
        if (r.gate_count <= 4'h1) begin
          next_r.state = PCS_ARMED;
          next_r.gate_count = 4'h0;
        end else begin
          next_r.gate_count = r.gate_count - 4'h1;
        end
      end
      PCS_ARMED: begin
        if (!pg_s) begin
          // back to waiting: internal reset must not leak out early
          next_r.state = PCS_WAIT_POWER;
          next_r.irst_n = 1'b1;
        end else if (!prst_n_s) begin
          next_r.sel = pcs_pick(clk1_s, clk2_s);
          next_r.valid = 1'b1;
          next_r.mhz = 7'(PCI_SLOW_MHZ);
          next_r.state = PCS_LOCKED;
        end
      end
      PCS_LOCKED: begin
        // later resets leave the choice alone; only rst clears it
        next_r.state = PCS_LOCKED;
      end
      default: begin
        next_r.state = PCS_WAIT_POWER;
      end
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      r.state <= PCS_WAIT_POWER;
      r.gate_count <= 4'h0;
      r.pg_prev <= 1'b0;
      r.irst_n <= 1'b1;
      r.sel <= SEL_RESET;
      r.valid <= 1'b0;
      r.mhz <= 7'h00;
      r.pwr_good <= 1'b0;
      r.tap_reset <= 1'b1;
    end else if (clock_enable) begin
      r <= next_r;
    end
  end

  assign clock_detect_reset_n = r.irst_n;
  assign source_select = r.sel;
  assign select_valid = r.valid;
  assign pci_clock_mhz = r.mhz;
  assign board_power_good = r.pwr_good;
  assign test_port_reset = r.tap_reset;

  // ================================================================
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  // one extra cycle of hold is harmless; one too few is the fault
  gate_hold_a: assert property (
    clock_enable && r.state == PCS_WAIT_POWER
    && pcs_pg_rise(pg_s, r.pg_prev)
    |=> clock_detect_reset_n [*6])
    else $error("internal reset asserted inside gate window");

  gate_exit_a: assert property (
    clock_enable && r.state == PCS_GATE && r.gate_count <= 4'h1
    |=> r.state == PCS_ARMED && !select_valid)
    else $error("gate window did not end in the armed state");

  gate_length_a: assert property (
    r.state == PCS_GATE |-> r.gate_count <= 4'h6)
    else $error("gate counter beyond window");

  no_early_a: assert property (
    r.state == PCS_WAIT_POWER |-> clock_detect_reset_n)
    else $error("internal reset before power-good edge");

  sample_cause_a: assert property (
    $rose(select_valid) |-> $past(pg_s) && !$past(prst_n_s))
    else $error("sample taken without power-good and reset");

  // a lock may only come out of the armed state
  lock_source_a: assert property (
    !select_valid && r.state != PCS_ARMED |=> !select_valid)
    else $error("choice latched outside the armed state");

  follow_reset_a: assert property (
    clock_enable && r.state == PCS_LOCKED
    |=> clock_detect_reset_n == $past(prst_n_s))
    else $error("internal reset does not follow bridge reset");

  pick_value_a: assert property (
    clock_enable && r.state == PCS_ARMED && pg_s && !prst_n_s
    |=> source_select ==
      ($past(clk1_s && !clk2_s) ? SEL_SOURCE_C : SEL_SOURCE_B))
    else $error("source choice does not match sampled clocks");

  choice_stable_a: assert property (
    select_valid |=> select_valid && $stable(source_select))
    else $error("clock source choice changed after lock");

  lock_keep_a: assert property (
    r.state == PCS_LOCKED |=> r.state == PCS_LOCKED)
    else $error("locked state left without reset");

  speed_ok_a: assert property (
    select_valid |-> pci_clock_mhz == 7'h21)
    else $error("pci clock not 33 MHz after selection");

  speed_idle_a: assert property (
    !select_valid |-> pci_clock_mhz == 7'h00)
    else $error("pci clock speed shown before selection");

  tap_reset_a: assert property (
    clock_enable && !pg_s |=> test_port_reset && !board_power_good)
    else $error("test port not reset while power is bad");

  // power-good out trails the synced supply by one register
  power_follow_a: assert property (
    clock_enable |=> board_power_good == $past(pg_s))
    else $error("board power-good does not follow supply");

  // ================================================================
  // coverage
  lock_c: cover property ($rose(select_valid));
  pick_c_c: cover property ($rose(select_valid) && source_select);
  gate_c: cover property (r.state == PCS_GATE ##1 r.state == PCS_ARMED);
  relock_c: cover property (select_valid && !prst_n_s ##1 !pg_s);
  refuse_c: cover property (r.state == PCS_ARMED && !pg_s);
endmodule

// File: verification/pcs_bridge_model.sv
`timescale 1ns/1ps
// ==================================================================
// power supply and both bridges, reduced to plain pin levels
module pcs_bridge_model (
  input wire logic power_on,
  input wire logic reset_on,
  input wire logic [1:0] clk_level,
  output logic supply_power_good,
  output logic bridge_pci_reset_n,
  output logic bridge1_pci_clock_out,
  output logic bridge2_pci_clock_out
);
  assign supply_power_good = power_on;
  assign bridge_pci_reset_n = !reset_on;
  // levels only move outside the gate window, so no rise in it
  assign bridge1_pci_clock_out = clk_level[1];
  assign bridge2_pci_clock_out = clk_level[0];
endmodule

// File: verification/pcs_clock_select_tb.sv
`timescale 1ns/1ps
`define CHK(g, e) check(7'(g), 7'(e))
// ==================================================================
// bench
module pcs_clock_select_tb;
  import pcs_pkg::*;
  logic clock, rst, pwr, rsto, pg, prst_n, c1, c2, ce;
  logic irst_n, sel, valid, bpg, tpr;
  logic [1:0] lvl;
  logic [6:0] mhz;
  int fail_count, comparisons, i, n;
  // {bridge1 clock, bridge2 clock, expected choice}
  logic [2:0] rows [4] = '{3'b000, 3'b010, 3'b101, 3'b110};
  pcs_bridge_model i_model (.power_on(pwr), .reset_on(rsto),
    .clk_level(lvl), .supply_power_good(pg), .bridge_pci_reset_n(prst_n),
    .bridge1_pci_clock_out(c1), .bridge2_pci_clock_out(c2));
  pcs_clock_select i_dut (.clock(clock), .rst(rst), .clock_enable(ce),
    .supply_power_good(pg), .bridge_pci_reset_n(prst_n),
    .bridge1_pci_clock_out(c1), .bridge2_pci_clock_out(c2),
    .clock_detect_reset_n(irst_n), .source_select(sel),
    .select_valid(valid), .pci_clock_mhz(mhz),
    .board_power_good(bpg), .test_port_reset(tpr));
  initial begin
    clock = 0;
    forever #4 clock = ~clock;
  end
  task check(input logic [6:0] g, input logic [6:0] e);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task cyc(input int k);
    repeat (k) @(negedge clock);
  endtask
  // bounded wait; running out ends the run as a failure
  task wait_valid;
    n = 0;
    while (valid !== 1'b1 && n < 40) begin
      cyc(1);
      n++;
    end
    if (valid !== 1'b1) begin
      fail_count++;
      report_and_stop;
    end
  endtask
  initial begin
    rst = 1;
    pwr = 0;
    rsto = 0;
    lvl = 0;
    ce = 1;
    cyc(16);
    `CHK(tpr, 1);
    `CHK(irst_n, 1);
    `CHK(valid, 0);
    $display("test reset done");
    for (i = 0; i < 4; i++) begin
      lvl = rows[i][2:1];
      rst = 1;
      cyc(16);
      rst = 0;
      cyc(2);
      pwr = 1;
      cyc(4);
      `CHK(bpg, 1);
      `CHK(tpr, 0);
      cyc(6);
      rsto = 1;
      wait_valid;
      `CHK(sel, rows[i][0]);
      `CHK(mhz, PCI_SLOW_MHZ);
      `CHK(irst_n, 0);
      rsto = 0;
      pwr = 0;
      $display("test row %0d done", i);
    end
    // bridge reset already low before power-good: no early lock
    lvl = 2'b10;
    rst = 1;
    rsto = 1;
    cyc(16);
    rst = 0;
    cyc(8);
    `CHK(valid, 0);
    `CHK(irst_n, 1);
    pwr = 1;
    for (i = 0; i < GATE_CYCLES; i++) begin
      cyc(1);
      `CHK(irst_n, 1);
    end
    wait_valid;
    `CHK(sel, SEL_SOURCE_C);
    // later resets and clock changes must leave the choice alone
    lvl = 2'b00;
    rsto = 0;
    cyc(5);
    rsto = 1;
    pwr = 0;
    cyc(5);
    pwr = 1;
    cyc(12);
    `CHK(sel, SEL_SOURCE_C);
    `CHK(valid, 1);
    `CHK(mhz, PCI_SLOW_MHZ);
    `CHK(irst_n, 0);
    $display("test relock done");
    // power-good lost while armed: no lock, internal reset stays off
    rst = 1;
    rsto = 0;
    pwr = 0;
    lvl = 2'b10;
    cyc(16);
    rst = 0;
    cyc(2);
    pwr = 1;
    cyc(12);
    pwr = 0;
    rsto = 1;
    cyc(3);
    `CHK(valid, 0);
    `CHK(irst_n, 1);
    `CHK(tpr, 1);
    `CHK(bpg, 0);
    // clock enable low freezes everything, synchronisers too
    ce = 0;
    pwr = 1;
    cyc(10);
    `CHK(bpg, 0);
    `CHK(valid, 0);
    ce = 1;
    cyc(4);
    `CHK(bpg, 1);
    `CHK(irst_n, 1);
    wait_valid;
    `CHK(sel, SEL_SOURCE_C);
    $display("test refuse done");
    report_and_stop;
  end
endmodule
